/* File: hw/pmcg_map.svh */
// register offsets, field positions and reset values
`ifndef PMCG_MAP_SVH
`define PMCG_MAP_SVH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define OFS_POWER_MODE 8'h00
`define OFS_LVW_CTRL 8'h04
`define OFS_CLK_GATE_ONE 8'h08
`define OFS_IRQ_STATUS 8'h0c
`define OFS_IRQ_MASK 8'h10

// ----------------------------------------------------------------------
// power mode control and status fields
// ----------------------------------------------------------------------
`define BIT_LP_REG_REQ 7
`define BIT_REG_STANDBY 6
`define BIT_WAKE_REG_IRQ 5
`define BIT_PARTIAL_POWER_DOWN_STOP_FLAG 3
`define BIT_PARTIAL_POWER_DOWN_STOP_ACK 2
`define BIT_DEEP_STOP_EN 1
`define BIT_DEEP_STOP_SEL 0

// ----------------------------------------------------------------------
// low-voltage warning fields
// ----------------------------------------------------------------------
`define BIT_LVW_FLAG 7
`define BIT_LVW_ACK 6
`define BIT_LVW_IRQ_EN 3

// ----------------------------------------------------------------------
// clock gate fields
// ----------------------------------------------------------------------
`define BIT_CG_TIMER_TWO 6
`define BIT_CG_TIMER_ONE 5
`define BIT_CG_ADC 4
`define BIT_CG_TWO_WIRE 2
`define BIT_CG_ASYNC_SERIAL 0
`define CG_USED_MASK 8'h75

// ----------------------------------------------------------------------
// interrupt status fields
// ----------------------------------------------------------------------
`define BIT_EV_LVW 0
`define BIT_EV_PARTIAL_POWER_DOWN_STOP 1
`define BIT_EV_REQ_CLR 2
`define EV_COUNT 3

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define RST_CLK_GATE_ONE 8'h75
`define RST_IRQ_MASK 3'h0

`endif

/* File: hw/pmcg_pkg.sv */
// types shared by the power mode and clock gate register bank
package pmcg_pkg;

    typedef logic [7:0] reg_byte_t;
    typedef logic [31:0] bus_word_t;

    // bus slave handshake phases
    typedef enum logic [0:0] {
        BUS_IDLE,
        BUS_ACK
    } bus_state_t;

    // stop mode that a stop instruction would enter
    typedef enum logic [0:0] {
        STOP_LIGHT,
        STOP_PARTIAL_POWER_DOWN
    } stop_mode_t;

endpackage : pmcg_pkg

/* File: hw/power_mode_and_clock_gate_regs.sv */
// power mode, low-voltage warning and clock gate register bank
//
// Notes on behaviour
// - setting the regulator request bit asks for low power run and wait.
// - regulator request cannot be set while deep stop select is 1.
// - deep stop select cannot be set while regulator request is 1.
// - writing both bits at once sets only deep stop select.
// - an interrupt clears the regulator request when wake-on-interrupt is 1.
// - standby status reads 1 only while the regulator is in standby.
// - wake-on-interrupt 1 makes regulator leave standby on interrupt.
// - partial_power_down_stop recovery flag reads 1 after recovery from deep stop.
// - writing 1 to partial_power_down_stop acknowledge clears the recovery flag.
// - deep stop enable is write-once; 0 locks out partial power down.
// - deep stop select chooses light stop (0) or partial power down (1).
// - warning acknowledge clears the flag only if no warning is present.
// - warning interrupt enable raises a request while the flag is 1.
// - timer two, timer one and ADC clock gates pass clock when 1.
// - two-wire serial clock gate passes its clock when 1.
// - async serial clock gate passes its clock when 1.
`timescale 1ns/1ps
`include "pmcg_map.svh"

module power_mode_and_clock_gate_regs #(
    parameter int ADDR_W = 8
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    // avalon-mm slave
    input wire logic [ADDR_W-1:0] i_address,
    input wire logic i_read,
    input wire logic i_write,
    input wire pmcg_pkg::bus_word_t i_writedata,
    input wire logic [3:0] i_byteenable,
    output logic o_waitrequest,
    output pmcg_pkg::bus_word_t o_readdata,
    // system status inputs
    input wire logic i_cpu_interrupt,
    input wire logic i_regulator_in_standby,
    input wire logic i_partial_power_down_stop_recovered,
    input wire logic i_supply_below_warning,
    // power mode controls
    output logic o_low_power_regulator_request,
    output logic o_regulator_exit_standby,
    output logic o_partial_power_down_allowed,
    output pmcg_pkg::stop_mode_t o_stop_mode,
    output logic o_low_voltage_warning_irq,
    // peripheral bus clock enables
    output logic o_clk_en_timer_unit_two,
    output logic o_clk_en_timer_unit_one,
    output logic o_clk_en_adc,
    output logic o_clk_en_two_wire_serial_unit,
    output logic o_clk_en_async_serial_unit,
    // summary interrupt
    output logic o_irq
);
    import pmcg_pkg::*;

    // ------------------------------------------------------------------
    // register state
    // ------------------------------------------------------------------
    logic low_power_regulator_request_q;
    logic wake_regulator_on_interrupt_q;
    logic partial_power_down_stop_recovery_flag_q;
    logic deep_stop_enable_q;
    logic deep_stop_enable_written_q;
    logic deep_stop_select_q;
    logic low_voltage_warning_flag_q;
    logic low_voltage_warning_irq_enable_q;
    reg_byte_t clk_gate_one_q;
    logic [`EV_COUNT-1:0] irq_status_q;
    logic [`EV_COUNT-1:0] irq_mask_q;
    bus_state_t bus_state_q;

    // ------------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------------
    logic req;
    logic accept;
    logic wr_lane0;
    logic rd_accept;
    reg_byte_t wbyte;

    function automatic logic hit(input logic [ADDR_W-1:0] addr,
                                 input logic [7:0] ofs);
        hit = (addr == ADDR_W'(ofs));
    endfunction : hit

    assign req = i_read | i_write;
    assign accept = req && (bus_state_q == BUS_ACK);
    assign wr_lane0 = accept && i_write && i_byteenable[0];
    assign rd_accept = accept && i_read;
    assign wbyte = i_writedata[7:0];

    logic wr_power;
    logic wr_lvw;
    logic wr_gate;
    logic wr_mask;
    logic rd_status;

    assign wr_power = wr_lane0 && hit(i_address, `OFS_POWER_MODE);
    assign wr_lvw = wr_lane0 && hit(i_address, `OFS_LVW_CTRL);
    assign wr_gate = wr_lane0 && hit(i_address, `OFS_CLK_GATE_ONE);
    assign wr_mask = wr_lane0 && hit(i_address, `OFS_IRQ_MASK);
    assign rd_status = rd_accept && hit(i_address, `OFS_IRQ_STATUS);

    // ------------------------------------------------------------------
    // bus handshake: one wait cycle, then accept
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            bus_state_q <= BUS_IDLE;
            o_waitrequest <= 1'b1;
        end else if (i_ce) begin
            unique case (bus_state_q)
                BUS_IDLE: begin
                    if (req) begin
                        bus_state_q <= BUS_ACK;
                        o_waitrequest <= 1'b0;
                    end
                end
                BUS_ACK: begin
                    bus_state_q <= BUS_IDLE;
                    o_waitrequest <= 1'b1;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // read data, captured one cycle ahead of the accept edge
    // ------------------------------------------------------------------
    reg_byte_t power_rd;
    reg_byte_t lvw_rd;
    reg_byte_t rd_byte;

    always_comb begin
        power_rd = 8'h00;
        power_rd[`BIT_LP_REG_REQ] = low_power_regulator_request_q;
        power_rd[`BIT_REG_STANDBY] = i_regulator_in_standby;
        power_rd[`BIT_WAKE_REG_IRQ] = wake_regulator_on_interrupt_q;
        power_rd[`BIT_PARTIAL_POWER_DOWN_STOP_FLAG] = partial_power_down_stop_recovery_flag_q;
        power_rd[`BIT_DEEP_STOP_EN] = deep_stop_enable_q;
        power_rd[`BIT_DEEP_STOP_SEL] = deep_stop_select_q;
        lvw_rd = 8'h00;
        lvw_rd[`BIT_LVW_FLAG] = low_voltage_warning_flag_q;
        lvw_rd[`BIT_LVW_IRQ_EN] = low_voltage_warning_irq_enable_q;
    end

    always_comb begin
        // reserved and acknowledge bits read zero
        rd_byte = 8'h00;
        if (hit(i_address, `OFS_POWER_MODE)) begin
            rd_byte = power_rd;
        end else if (hit(i_address, `OFS_LVW_CTRL)) begin
            rd_byte = lvw_rd;
        end else if (hit(i_address, `OFS_CLK_GATE_ONE)) begin
            rd_byte = clk_gate_one_q & `CG_USED_MASK;
        end else if (hit(i_address, `OFS_IRQ_STATUS)) begin
            rd_byte = {5'h00, irq_status_q};
        end else if (hit(i_address, `OFS_IRQ_MASK)) begin
            rd_byte = {5'h00, irq_mask_q};
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_readdata <= 32'h0000_0000;
        end else if (i_ce) begin
            if (bus_state_q == BUS_IDLE && i_read) begin
                o_readdata <= {24'h00_0000, rd_byte};
            end
        end
    end

    // ------------------------------------------------------------------
    // power mode control
    // ------------------------------------------------------------------
    logic req_auto_clear;
    logic set_dss;
    logic set_req;

    assign req_auto_clear = i_cpu_interrupt && wake_regulator_on_interrupt_q
                            && low_power_regulator_request_q;
    // select refused while request is set
    assign set_dss = wbyte[`BIT_DEEP_STOP_SEL]
                     && !low_power_regulator_request_q;
    // request refused while select is set
    // simultaneous write keeps only the select
    assign set_req = wbyte[`BIT_LP_REG_REQ] && !deep_stop_select_q
                     && !wbyte[`BIT_DEEP_STOP_SEL];

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            low_power_regulator_request_q <= 1'b0;
        end else if (i_ce) begin
            if (req_auto_clear) begin
                low_power_regulator_request_q <= 1'b0;
            end else if (wr_power) begin
                low_power_regulator_request_q <= set_req;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            deep_stop_select_q <= 1'b0;
            wake_regulator_on_interrupt_q <= 1'b0;
        end else if (i_ce) begin
            if (wr_power) begin
                deep_stop_select_q <= set_dss;
                wake_regulator_on_interrupt_q <= wbyte[`BIT_WAKE_REG_IRQ];
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            deep_stop_enable_q <= 1'b0;
            deep_stop_enable_written_q <= 1'b0;
        end else if (i_ce) begin
            if (wr_power && !deep_stop_enable_written_q) begin
                deep_stop_enable_q <= wbyte[`BIT_DEEP_STOP_EN];
                deep_stop_enable_written_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            partial_power_down_stop_recovery_flag_q <= 1'b0;
        end else if (i_ce) begin
            if (i_partial_power_down_stop_recovered) begin
                partial_power_down_stop_recovery_flag_q <= 1'b1;
            end else if (wr_power && wbyte[`BIT_PARTIAL_POWER_DOWN_STOP_ACK]) begin
                partial_power_down_stop_recovery_flag_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // low-voltage warning
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            low_voltage_warning_flag_q <= 1'b0;
        end else if (i_ce) begin
            if (i_supply_below_warning) begin
                low_voltage_warning_flag_q <= 1'b1;
            end else if (wr_lvw && wbyte[`BIT_LVW_ACK]) begin
                low_voltage_warning_flag_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            low_voltage_warning_irq_enable_q <= 1'b0;
        end else if (i_ce) begin
            if (wr_lvw) begin
                low_voltage_warning_irq_enable_q <= wbyte[`BIT_LVW_IRQ_EN];
            end
        end
    end

    // ------------------------------------------------------------------
    // clock gates
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            clk_gate_one_q <= `RST_CLK_GATE_ONE;
        end else if (i_ce) begin
            if (wr_gate) begin
                clk_gate_one_q <= wbyte & `CG_USED_MASK;
            end
        end
    end

    // ------------------------------------------------------------------
    // event status and mask
    // ------------------------------------------------------------------
    logic [`EV_COUNT-1:0] events;

    assign events[`BIT_EV_LVW] = i_supply_below_warning
                                 && !low_voltage_warning_flag_q;
    assign events[`BIT_EV_PARTIAL_POWER_DOWN_STOP] = i_partial_power_down_stop_recovered;
    assign events[`BIT_EV_REQ_CLR] = req_auto_clear;

    genvar g;
    generate
        for (g = 0; g < `EV_COUNT; g++) begin : g_status
            always_ff @(posedge i_clk) begin
                if (!i_rst_n) begin
                    irq_status_q[g] <= 1'b0;
                end else if (i_ce) begin
                    // set wins over read clear
                    if (events[g]) begin
                        irq_status_q[g] <= 1'b1;
                    end else if (rd_status) begin
                        irq_status_q[g] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            irq_mask_q <= `RST_IRQ_MASK;
        end else if (i_ce) begin
            if (wr_mask) begin
                irq_mask_q <= wbyte[`EV_COUNT-1:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // registered outputs
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_irq <= 1'b0;
            o_low_voltage_warning_irq <= 1'b0;
        end else if (i_ce) begin
            o_irq <= |(irq_status_q & irq_mask_q);
            o_low_voltage_warning_irq <= low_voltage_warning_flag_q
                                         && low_voltage_warning_irq_enable_q;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_low_power_regulator_request <= 1'b0;
            o_regulator_exit_standby <= 1'b0;
            o_partial_power_down_allowed <= 1'b0;
            o_stop_mode <= STOP_LIGHT;
        end else if (i_ce) begin
            o_low_power_regulator_request <= low_power_regulator_request_q;
            o_regulator_exit_standby <= i_cpu_interrupt
                                        && wake_regulator_on_interrupt_q;
            o_partial_power_down_allowed <= deep_stop_enable_q;
            o_stop_mode <= (deep_stop_enable_q && deep_stop_select_q)
                           ? STOP_PARTIAL_POWER_DOWN : STOP_LIGHT;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_clk_en_timer_unit_two <= 1'b0;
            o_clk_en_timer_unit_one <= 1'b0;
            o_clk_en_adc <= 1'b0;
            o_clk_en_two_wire_serial_unit <= 1'b0;
            o_clk_en_async_serial_unit <= 1'b0;
        end else if (i_ce) begin
            o_clk_en_timer_unit_two <= clk_gate_one_q[`BIT_CG_TIMER_TWO];
            o_clk_en_timer_unit_one <= clk_gate_one_q[`BIT_CG_TIMER_ONE];
            o_clk_en_adc <= clk_gate_one_q[`BIT_CG_ADC];
            o_clk_en_two_wire_serial_unit <= clk_gate_one_q[`BIT_CG_TWO_WIRE];
            o_clk_en_async_serial_unit <= clk_gate_one_q[`BIT_CG_ASYNC_SERIAL];
        end
    end

endmodule : power_mode_and_clock_gate_regs

/* File: verification/power_mode_and_clock_gate_regs_chk.sv */
// checker for bus handshake, power mode and clock gate relations
`timescale 1ns/1ps
`include "pmcg_map.svh"

module power_mode_and_clock_gate_regs_chk
    import pmcg_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [ADDR_W-1:0] i_address,
    input wire logic i_read,
    input wire logic i_write,
    input wire pmcg_pkg::bus_word_t i_writedata,
    input wire logic [3:0] i_byteenable,
    input wire logic o_waitrequest,
    input wire pmcg_pkg::bus_word_t o_readdata,
    input wire logic i_cpu_interrupt,
    input wire logic o_low_power_regulator_request,
    input wire logic o_regulator_exit_standby,
    input wire logic o_partial_power_down_allowed,
    input wire pmcg_pkg::stop_mode_t o_stop_mode,
    input wire logic o_clk_en_timer_unit_two,
    input wire logic o_clk_en_timer_unit_one,
    input wire logic o_clk_en_adc,
    input wire logic o_clk_en_two_wire_serial_unit,
    input wire logic o_clk_en_async_serial_unit
);
    logic gate_wr;
    logic [7:0] cg;

    // accepted write to the clock gate register
    assign gate_wr = i_write && !o_waitrequest && i_byteenable[0]
        && (i_address == ADDR_W'(`OFS_CLK_GATE_ONE));
    assign cg = {1'b0, o_clk_en_timer_unit_two, o_clk_en_timer_unit_one,
        o_clk_en_adc, 1'b0, o_clk_en_two_wire_serial_unit, 1'b0,
        o_clk_en_async_serial_unit};

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_n);

    chk_wait_pulse: assert property (
        !o_waitrequest |=> o_waitrequest)
        else $error("waitrequest low for more than one cycle");
    chk_wait_answer: assert property (
        $rose(i_read || i_write) |=> !o_waitrequest)
        else $error("request not answered in the next cycle");
    chk_rdata_upper: assert property (
        !o_waitrequest && i_read |-> o_readdata[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    chk_req_excludes_sel: assert property (
        o_low_power_regulator_request |-> o_stop_mode == STOP_LIGHT)
        else $error("regulator request and deep stop both active");
    chk_mode_needs_en: assert property (
        o_stop_mode == STOP_PARTIAL_POWER_DOWN
        |-> ##[0:1] o_partial_power_down_allowed)
        else $error("deep stop selected while locked out");
    chk_enable_sticky: assert property (
        $past(o_partial_power_down_allowed)
        |-> o_partial_power_down_allowed)
        else $error("deep stop enable changed after first write");
    chk_exit_cause: assert property (
        o_regulator_exit_standby |-> $past(i_cpu_interrupt))
        else $error("regulator exit without an interrupt");
    chk_auto_clear: assert property (
        o_regulator_exit_standby && o_low_power_regulator_request
        |=> !o_low_power_regulator_request)
        else $error("regulator request not cleared by interrupt");
    chk_gate_value: assert property (
        $past(gate_wr, 2) |-> cg == ($past(i_writedata[7:0], 2) & 8'h75))
        else $error("clock enables differ from written gate bits");
    chk_gate_stable: assert property (
        !$stable(cg) && $past(i_rst_n, 4) |-> $past(gate_wr, 2))
        else $error("clock enable changed without a gate write");
endmodule : power_mode_and_clock_gate_regs_chk

bind power_mode_and_clock_gate_regs power_mode_and_clock_gate_regs_chk #(
    .ADDR_W(ADDR_W)
) u_chk (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_address(i_address),
    .i_read(i_read), .i_write(i_write), .i_writedata(i_writedata),
    .i_byteenable(i_byteenable), .o_waitrequest(o_waitrequest),
    .o_readdata(o_readdata), .i_cpu_interrupt(i_cpu_interrupt),
    .o_low_power_regulator_request(o_low_power_regulator_request),
    .o_regulator_exit_standby(o_regulator_exit_standby),
    .o_partial_power_down_allowed(o_partial_power_down_allowed),
    .o_stop_mode(o_stop_mode),
    .o_clk_en_timer_unit_two(o_clk_en_timer_unit_two),
    .o_clk_en_timer_unit_one(o_clk_en_timer_unit_one),
    .o_clk_en_adc(o_clk_en_adc),
    .o_clk_en_two_wire_serial_unit(o_clk_en_two_wire_serial_unit),
    .o_clk_en_async_serial_unit(o_clk_en_async_serial_unit)
);

/* File: verification/power_mode_and_clock_gate_regs_tb.sv */
// testbench for the power mode and clock gate register bank
`timescale 1ns/1ps

module power_mode_and_clock_gate_regs_tb;
    import pmcg_pkg::*;
    logic i_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic [7:0] i_address = 8'h00;
    logic i_read = 1'b0;
    logic i_write = 1'b0;
    bus_word_t i_writedata = '0;
    logic [3:0] i_byteenable = 4'h1;
    logic i_cpu_interrupt = 1'b0;
    logic i_regulator_in_standby = 1'b0;
    logic i_partial_power_down_stop_recovered = 1'b0;
    logic i_supply_below_warning = 1'b0;
    logic o_waitrequest, o_low_power_regulator_request, o_irq;
    logic o_regulator_exit_standby, o_partial_power_down_allowed;
    logic o_low_voltage_warning_irq, o_clk_en_timer_unit_two;
    logic o_clk_en_timer_unit_one, o_clk_en_adc, o_clk_en_async_serial_unit;
    logic o_clk_en_two_wire_serial_unit;
    bus_word_t o_readdata;
    stop_mode_t o_stop_mode;
    logic [7:0] cg_seen;
    int n_errors = 0;
    int comparisons = 0;
    int cycles = 0;

    assign cg_seen = {1'b0, o_clk_en_timer_unit_two, o_clk_en_timer_unit_one,
        o_clk_en_adc, 1'b0, o_clk_en_two_wire_serial_unit, 1'b0,
        o_clk_en_async_serial_unit};

    always #5 i_clk = ~i_clk;

    power_mode_and_clock_gate_regs u_dut (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(1'b1),
        .i_address(i_address), .i_read(i_read), .i_write(i_write),
        .i_writedata(i_writedata), .i_byteenable(i_byteenable),
        .o_waitrequest(o_waitrequest), .o_readdata(o_readdata),
        .i_cpu_interrupt(i_cpu_interrupt),
        .i_regulator_in_standby(i_regulator_in_standby),
        .i_partial_power_down_stop_recovered(i_partial_power_down_stop_recovered),
        .i_supply_below_warning(i_supply_below_warning),
        .o_low_power_regulator_request(o_low_power_regulator_request),
        .o_regulator_exit_standby(o_regulator_exit_standby),
        .o_partial_power_down_allowed(o_partial_power_down_allowed),
        .o_stop_mode(o_stop_mode),
        .o_low_voltage_warning_irq(o_low_voltage_warning_irq),
        .o_clk_en_timer_unit_two(o_clk_en_timer_unit_two),
        .o_clk_en_timer_unit_one(o_clk_en_timer_unit_one),
        .o_clk_en_adc(o_clk_en_adc),
        .o_clk_en_two_wire_serial_unit(o_clk_en_two_wire_serial_unit),
        .o_clk_en_async_serial_unit(o_clk_en_async_serial_unit),
        .o_irq(o_irq)
    );

    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : give_verdict

    task automatic chk(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // holds the request until waitrequest is sampled low; a hang ends
    // at the bench timeout
    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [7:0] d, output logic [7:0] q);
        i_address <= a;
        i_writedata <= {24'h0, d};
        i_write <= wr;
        i_read <= ~wr;
        @(posedge i_clk);
        while (o_waitrequest !== 1'b0) begin
            @(posedge i_clk);
        end
        q = o_readdata[7:0];
        i_write <= 1'b0;
        i_read <= 1'b0;
        @(posedge i_clk);
    endtask : bus

    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] q;
        bus(1'b0, a, 8'h00, q);
        chk($sformatf("register %h", a), exp, q);
    endtask : rdc

    task automatic wrc(input logic [7:0] a, d, exp);
        logic [7:0] q;
        bus(1'b1, a, d, q);
        rdc(a, exp);
    endtask : wrc

    task automatic wait_n(input int n);
        repeat (n) @(posedge i_clk);
    endtask : wait_n

    always @(posedge i_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_errors++;
            $display("mismatch run length expected end seen timeout");
            give_verdict();
        end
    end

    // ----------------------------------------------------------------
    // tests
    // ----------------------------------------------------------------
    initial begin
        wait_n(8);
        i_rst_n <= 1'b1;
        wait_n(3);
        rdc(8'h00, 8'h00);
        rdc(8'h04, 8'h00);
        rdc(8'h08, 8'h75);
        rdc(8'h0c, 8'h00);
        rdc(8'h10, 8'h00);
        chk("clock enables", 8'h75, cg_seen);
        $display("test reset done");
        for (int i = 0; i < 8; i++) begin
            wrc(8'h08, 8'h01 << i, (8'h01 << i) & 8'h75);
            wait_n(2);
            chk("clock enables", (8'h01 << i) & 8'h75, cg_seen);
        end
        i_byteenable <= 4'he;
        wrc(8'h08, 8'hff, 8'h00);
        i_byteenable <= 4'h1;
        wrc(8'h08, 8'hff, 8'h75);
        wrc(8'h14, 8'hff, 8'h00);
        $display("test clock gates done");
        wrc(8'h00, 8'h83, 8'h03);
        wait_n(2);
        chk("stop mode", 8'h01, {7'h0, o_stop_mode});
        chk("deep stop allowed", 8'h01, {7'h0, o_partial_power_down_allowed});
        wrc(8'h00, 8'h80, 8'h02);
        wrc(8'h00, 8'h80, 8'h82);
        wrc(8'h00, 8'h81, 8'h02);
        wrc(8'h00, 8'h80, 8'h82);
        wrc(8'h00, 8'h01, 8'h02);
        wrc(8'h00, 8'h80, 8'h82);
        chk("regulator request", 8'h01, {7'h0, o_low_power_regulator_request});
        i_cpu_interrupt <= 1'b1;
        wait_n(3);
        chk("regulator exit", 8'h00, {7'h0, o_regulator_exit_standby});
        i_cpu_interrupt <= 1'b0;
        rdc(8'h00, 8'h82);
        wrc(8'h00, 8'ha0, 8'ha2);
        i_cpu_interrupt <= 1'b1;
        wait_n(3);
        chk("regulator exit", 8'h01, {7'h0, o_regulator_exit_standby});
        i_cpu_interrupt <= 1'b0;
        rdc(8'h00, 8'h22);
        chk("regulator request", 8'h00, {7'h0, o_low_power_regulator_request});
        i_regulator_in_standby <= 1'b1;
        rdc(8'h00, 8'h62);
        i_regulator_in_standby <= 1'b0;
        i_partial_power_down_stop_recovered <= 1'b1;
        wait_n(1);
        i_partial_power_down_stop_recovered <= 1'b0;
        rdc(8'h00, 8'h2a);
        wrc(8'h00, 8'h24, 8'h22);
        $display("test power mode done");
        wrc(8'h04, 8'h48, 8'h08);
        i_supply_below_warning <= 1'b1;
        wait_n(3);
        rdc(8'h04, 8'h88);
        chk("warning irq", 8'h01, {7'h0, o_low_voltage_warning_irq});
        wrc(8'h04, 8'h48, 8'h88);
        i_supply_below_warning <= 1'b0;
        rdc(8'h04, 8'h88);
        wrc(8'h04, 8'h00, 8'h80);
        chk("warning irq", 8'h00, {7'h0, o_low_voltage_warning_irq});
        wrc(8'h04, 8'h40, 8'h00);
        $display("test warning done");
        rdc(8'h0c, 8'h07);
        chk("summary irq", 8'h00, {7'h0, o_irq});
        rdc(8'h0c, 8'h00);
        wrc(8'h10, 8'hff, 8'h07);
        wrc(8'h10, 8'h01, 8'h01);
        i_supply_below_warning <= 1'b1;
        wait_n(4);
        chk("summary irq", 8'h01, {7'h0, o_irq});
        rdc(8'h0c, 8'h01);
        wait_n(2);
        chk("summary irq", 8'h00, {7'h0, o_irq});
        i_supply_below_warning <= 1'b0;
        $display("test interrupts done");
        give_verdict();
    end
endmodule : power_mode_and_clock_gate_regs_tb
